// File: rtl/pber_pkg.sv
package pber_pkg;

    // ****************************************************************
    // Register map (byte addresses, one word each)
    // ****************************************************************
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_STATUS    = 8'h04;
    localparam logic [7:0] ADDR_EVT_CFG   = 8'h08;
    localparam logic [7:0] ADDR_CNT_START = 8'h0c;
    localparam logic [7:0] ADDR_CNT_TRIP  = 8'h10;
    localparam logic [7:0] ADDR_CNT_BLK   = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h18;
    localparam logic [7:0] ADDR_IRQ_EN    = 8'h1c;
    localparam logic [7:0] ADDR_IRQ_CLR   = 8'h20;
    localparam logic [7:0] ADDR_REC_SEL   = 8'h24;
    localparam logic [7:0] ADDR_REC_META  = 8'h28;
    localparam logic [7:0] ADDR_REC_TIME  = 8'h2c;
    localparam logic [7:0] ADDR_REC_CUR   = 8'h30;
    localparam logic [7:0] ADDR_REC_VOLT  = 8'h34;
    localparam logic [7:0] ADDR_REC_COUNT = 8'h38;
    localparam logic [7:0] ADDR_REC_EXT   = 8'h3c;

    // ****************************************************************
    // Control register fields
    // ****************************************************************
    localparam int CTRL_FORCE_EN  = 0;
    localparam int CTRL_FORCE_LSB = 1;
    localparam int CTRL_CLR_START = 4;
    localparam int CTRL_CLR_TRIP  = 5;
    localparam int CTRL_CLR_BLK   = 6;

    // Event selection per event kind: 2 bits each, bit0 ON, bit1 OFF
    localparam logic [5:0] EVT_CFG_RESET = 6'h3f;

    localparam int REC_DEPTH = 12;
    localparam int CNT_W     = 16;
    localparam int MEAS_W    = 16;
    localparam int TS_W      = 32;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;

    typedef enum logic [1:0] {
        PBER_FORCE_NORMAL  = 2'h0,
        PBER_FORCE_START   = 2'h1,
        PBER_FORCE_TRIP    = 2'h2,
        PBER_FORCE_BLOCKED = 2'h3
    } pber_force_t;

    // Event codes: kind*2 + off flag
    typedef enum logic [2:0] {
        PBER_EV_START_ON  = 3'h0,
        PBER_EV_START_OFF = 3'h1,
        PBER_EV_TRIP_ON   = 3'h2,
        PBER_EV_TRIP_OFF  = 3'h3,
        PBER_EV_BLOCK_ON  = 3'h4,
        PBER_EV_BLOCK_OFF = 3'h5
    } pber_event_t;

    typedef struct packed {
        logic [MEAS_W-1:0] il1;
        logic [MEAS_W-1:0] il2;
        logic [MEAS_W-1:0] il3;
        logic [MEAS_W-1:0] u12;
        logic [MEAS_W-1:0] u23;
        logic [MEAS_W-1:0] u31;
        logic [2:0]        set_group;
    } pber_meas_t;

    typedef struct packed {
        logic [TS_W-1:0] stamp;
        pber_event_t     ev;
        pber_meas_t      meas;
    } pber_record_t;

    typedef struct packed {
        logic        valid;
        logic [2:0]  code;
        logic [TS_W-1:0] stamp;
    } pber_evt_msg_t;

endpackage

// File: rtl/pber_core.sv
`timescale 1ns/10ps

module pber_core #(
    parameter int CNT_W = pber_pkg::CNT_W
) (
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    input  wire logic               cycle_en,
    input  wire logic               block_in,
    input  wire logic               pickup_in,
    input  wire logic               over_current_in,
    input  wire logic [31:0]        time_in,
    input  wire pber_pkg::pber_meas_t meas_in,
    input  wire logic               hsel,
    input  wire logic [7:0]         haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic [31:0]             hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    output logic                    start_out,
    output logic                    trip_out,
    output logic                    blocked_out,
    output pber_pkg::pber_evt_msg_t evt_out,
    output logic                    irq
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [1:0]       blk_sync;
        logic [1:0]       pu_sync;
        logic [1:0]       oc_sync;
        logic             blk_smp;
        logic             start;
        logic             trip;
        logic             blocked;
        logic [2:0]       out_prev;
        logic [5:0]       evt_pend;
        pber_pkg::pber_evt_msg_t evt;
        logic [2:0]       rec_pend;
        logic [CNT_W-1:0] cnt_start;
        logic [CNT_W-1:0] cnt_trip;
        logic [CNT_W-1:0] cnt_blk;
        logic [3:0]       wr_ptr;
        logic [3:0]       rec_cnt;
        logic [3:0]       rec_sel;
        logic [7:0]       ctrl;
        logic [5:0]       evt_cfg;
        logic [5:0]       irq_stat;
        logic [5:0]       irq_en;
        logic             dp_act;
        logic             dp_wr;
        logic [7:0]       dp_addr;
        logic [31:0]      rdata;
        logic             irq;
    } pber_state_t;

    pber_state_t          s_q;
    pber_state_t          s_d;
    pber_pkg::pber_record_t rec_mem [pber_pkg::REC_DEPTH];
    logic                 rec_we;
    pber_pkg::pber_record_t rec_wdata;

    localparam logic [3:0] REC_LAST = 4'(pber_pkg::REC_DEPTH - 1);
    localparam logic [3:0] REC_FULL = 4'(pber_pkg::REC_DEPTH);
    localparam logic [CNT_W-1:0] CNT_MAX = '1;

    function automatic logic [CNT_W-1:0] sat_inc(
        input logic [CNT_W-1:0] v,
        input logic             inc,
        input logic             clr
    );
        // Clear wins over a count that lands in the same cycle
        return clr ? '0 : (inc && v != CNT_MAX) ? v + 1'b1 : v;
    endfunction

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic        blk, pu, oc, st, tr, bl;
        logic [2:0]  now, rise, fall, pick;
        logic [5:0]  chg, ev_bits;
        logic        clr_st, clr_tr, clr_bl;
        logic [31:0] rd;
        pber_pkg::pber_force_t fst;
        s_d      = s_q;
        rec_we   = 1'b0;
        rec_wdata = '0;
        clr_st   = 1'b0;
        clr_tr   = 1'b0;
        clr_bl   = 1'b0;
        blk = s_q.blk_smp;
        pu  = s_q.pu_sync[1];
        oc  = s_q.oc_sync[1];
        st  = s_q.start;
        tr  = s_q.trip;
        bl  = s_q.blocked;
        rise = '0;
        fall = '0;
        chg  = '0;
        ev_bits = '0;
        pick = '0;
        now  = s_q.out_prev;
        rd   = '0;
        fst  = pber_pkg::pber_force_t'(
            s_q.ctrl[pber_pkg::CTRL_FORCE_LSB +: 2]);
        // Two-stage synchronisers on the pins
        s_d.blk_sync = {s_q.blk_sync[0], block_in};
        s_d.pu_sync  = {s_q.pu_sync[0], pickup_in};
        s_d.oc_sync  = {s_q.oc_sync[0], over_current_in};
        s_d.evt.valid = 1'b0;
        if (cycle_en) begin
            // Block is latched first so this cycle's decision uses it
            blk = s_q.blk_sync[1];
            s_d.blk_smp = blk;
            if (pu && blk) begin
                bl = 1'b1;
                st = 1'b0;
                tr = 1'b0;
            end else if (pu) begin
                bl = 1'b0;
                st = 1'b1;
                tr = tr | oc;
            end else begin
                st = 1'b0;
                tr = 1'b0;
                bl = 1'b0;
            end
            s_d.start   = st;
            s_d.trip    = tr;
            s_d.blocked = bl;
            now = {bl, tr, st};
            if (s_q.ctrl[pber_pkg::CTRL_FORCE_EN]) begin
                // Forced status overrides the computed one
                case (fst)
                    pber_pkg::PBER_FORCE_START:   now = 3'h1;
                    pber_pkg::PBER_FORCE_TRIP:    now = 3'h3;
                    pber_pkg::PBER_FORCE_BLOCKED: now = 3'h4;
                    default:                      now = 3'h0;
                endcase
            end
            rise = now & ~s_q.out_prev;
            fall = ~now & s_q.out_prev;
            s_d.out_prev = now;
            chg = {fall[2], rise[2], fall[1], rise[1], fall[0], rise[0]};
            // Pending events filtered by selection
            s_d.evt_pend = s_q.evt_pend
                | (chg & s_q.evt_cfg);
            s_d.rec_pend = s_q.rec_pend | rise;
        end
        // One event message per clock, lowest code first
        for (int i = 5; i >= 0; i--) begin
            if (s_q.evt_pend[i]) begin
                ev_bits = 6'(1) << i;
            end
        end
        if (ev_bits != '0) begin
            s_d.evt_pend = s_d.evt_pend & ~ev_bits;
            s_d.evt.valid = 1'b1;
            s_d.evt.stamp = time_in;
            for (int i = 0; i < 6; i++) begin
                if (ev_bits[i]) begin
                    s_d.evt.code = 3'(i);
                end
            end
        end
        // One record per clock into the circular store
        for (int i = 2; i >= 0; i--) begin
            if (s_q.rec_pend[i]) begin
                pick = 3'(1) << i;
            end
        end
        if (pick != '0) begin
            rec_we = 1'b1;
            s_d.rec_pend = s_d.rec_pend & ~pick;
            rec_wdata.stamp = time_in;
            rec_wdata.meas  = meas_in;
            rec_wdata.ev    = pick[0] ? pber_pkg::PBER_EV_START_ON :
                              pick[1] ? pber_pkg::PBER_EV_TRIP_ON :
                                        pber_pkg::PBER_EV_BLOCK_ON;
            s_d.wr_ptr = (s_q.wr_ptr == REC_LAST) ? 4'h0
                       : s_q.wr_ptr + 4'h1;
            if (s_q.rec_cnt != REC_FULL) begin
                s_d.rec_cnt = s_q.rec_cnt + 4'h1;
            end
        end
        // Register writes in the data phase
        s_d.ctrl[pber_pkg::CTRL_CLR_BLK:pber_pkg::CTRL_CLR_START] = 3'h0;
        if (s_q.dp_act && s_q.dp_wr) begin
            if (s_q.dp_addr == pber_pkg::ADDR_CTRL) begin
                s_d.ctrl = hwdata[7:0];
                clr_st = hwdata[pber_pkg::CTRL_CLR_START];
                clr_tr = hwdata[pber_pkg::CTRL_CLR_TRIP];
                clr_bl = hwdata[pber_pkg::CTRL_CLR_BLK];
            end else if (s_q.dp_addr == pber_pkg::ADDR_EVT_CFG) begin
                s_d.evt_cfg = hwdata[5:0];
            end else if (s_q.dp_addr == pber_pkg::ADDR_IRQ_EN) begin
                s_d.irq_en = hwdata[5:0];
            end else if (s_q.dp_addr == pber_pkg::ADDR_IRQ_CLR) begin
                s_d.irq_stat = s_q.irq_stat & ~hwdata[5:0];
            end else if (s_q.dp_addr == pber_pkg::ADDR_REC_SEL) begin
                s_d.rec_sel = hwdata[3:0];
            end
        end
        // Sticky status: new events win over a clear in the same cycle
        s_d.irq_stat = s_d.irq_stat | chg;
        s_d.irq = |(s_d.irq_stat & s_d.irq_en);
        s_d.cnt_start = sat_inc(s_q.cnt_start, rise[0], clr_st);
        s_d.cnt_trip  = sat_inc(s_q.cnt_trip, rise[1], clr_tr);
        s_d.cnt_blk   = sat_inc(s_q.cnt_blk, rise[2], clr_bl);
        // Address phase; read data prepared for the data phase
        s_d.dp_act = 1'b0;
        if (hready) begin
            s_d.dp_act  = hsel && htrans == pber_pkg::HTRANS_NONSEQ
                        && hsize == pber_pkg::HSIZE_WORD;
            s_d.dp_wr   = hwrite;
            s_d.dp_addr = haddr;
            if (haddr == pber_pkg::ADDR_CTRL) begin
                rd = {24'h0, s_q.ctrl};
            end else if (haddr == pber_pkg::ADDR_STATUS) begin
                rd = {29'h0, s_q.out_prev};
            end else if (haddr == pber_pkg::ADDR_EVT_CFG) begin
                rd = {26'h0, s_q.evt_cfg};
            end else if (haddr == pber_pkg::ADDR_CNT_START) begin
                rd = 32'(s_q.cnt_start);
            end else if (haddr == pber_pkg::ADDR_CNT_TRIP) begin
                rd = 32'(s_q.cnt_trip);
            end else if (haddr == pber_pkg::ADDR_CNT_BLK) begin
                rd = 32'(s_q.cnt_blk);
            end else if (haddr == pber_pkg::ADDR_IRQ_STAT) begin
                rd = {26'h0, s_q.irq_stat};
            end else if (haddr == pber_pkg::ADDR_IRQ_EN) begin
                rd = {26'h0, s_q.irq_en};
            end else if (haddr == pber_pkg::ADDR_REC_SEL) begin
                rd = {28'h0, s_q.rec_sel};
            end else if (haddr == pber_pkg::ADDR_REC_COUNT) begin
                rd = {24'h0, s_q.wr_ptr, s_q.rec_cnt};
            end else if (s_q.rec_sel < REC_FULL) begin
                if (haddr == pber_pkg::ADDR_REC_META) begin
                    rd = {26'h0, rec_mem[s_q.rec_sel].meas.set_group,
                          rec_mem[s_q.rec_sel].ev};
                end else if (haddr == pber_pkg::ADDR_REC_TIME) begin
                    rd = rec_mem[s_q.rec_sel].stamp;
                end else if (haddr == pber_pkg::ADDR_REC_CUR) begin
                    rd = {rec_mem[s_q.rec_sel].meas.il2,
                          rec_mem[s_q.rec_sel].meas.il1};
                end else if (haddr == pber_pkg::ADDR_REC_VOLT) begin
                    rd = {rec_mem[s_q.rec_sel].meas.u23,
                          rec_mem[s_q.rec_sel].meas.u12};
                end else if (haddr == pber_pkg::ADDR_REC_EXT) begin
                    rd = {rec_mem[s_q.rec_sel].meas.u31,
                          rec_mem[s_q.rec_sel].meas.il3};
                end
            end
            s_d.rdata = rd;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q         <= '0;
            s_q.evt_cfg <= pber_pkg::EVT_CFG_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Record store has no reset; rec_cnt tells which entries are valid
    always_ff @(posedge core_clk) begin
        if (rec_we) begin
            rec_mem[s_q.wr_ptr] <= rec_wdata;
        end
    end

    // Outputs drive I/O and user logic directly
    assign start_out   = s_q.out_prev[0];
    assign trip_out    = s_q.out_prev[1];
    assign blocked_out = s_q.out_prev[2];
    assign evt_out     = s_q.evt;
    assign irq         = s_q.irq;
    assign hrdata      = s_q.rdata;
    assign hreadyout   = 1'b1;
    assign hresp       = 1'b0;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_block_wins;
        @(posedge core_clk) disable iff (!rst_n)
        (cycle_en && s_q.blk_sync[1] && s_q.pu_sync[1]
         && !s_q.ctrl[pber_pkg::CTRL_FORCE_EN])
        |=> (blocked_out && !start_out && !trip_out);
    endproperty
    a_block_wins: assert property (p_block_wins)
        else $error("blocked pick-up did not block");

    property p_start_free;
        @(posedge core_clk) disable iff (!rst_n)
        (cycle_en && !s_q.blk_sync[1] && s_q.pu_sync[1]
         && !s_q.ctrl[pber_pkg::CTRL_FORCE_EN]) |=> start_out;
    endproperty
    a_start_free: assert property (p_start_free)
        else $error("free pick-up did not start");

    property p_trip_oc;
        @(posedge core_clk) disable iff (!rst_n)
        (cycle_en && s_q.pu_sync[1] && s_q.oc_sync[1] && !s_q.blk_sync[1]
         && !s_q.ctrl[pber_pkg::CTRL_FORCE_EN]) |=> trip_out;
    endproperty
    a_trip_oc: assert property (p_trip_oc)
        else $error("over-current during start did not trip");

    property p_cnt_sat;
        @(posedge core_clk) disable iff (!rst_n)
        (s_q.cnt_start == CNT_MAX && !(s_q.dp_act && s_q.dp_wr
         && s_q.dp_addr == pber_pkg::ADDR_CTRL
         && hwdata[pber_pkg::CTRL_CLR_START]))
        |=> s_q.cnt_start == CNT_MAX;
    endproperty
    a_cnt_sat: assert property (p_cnt_sat)
        else $error("start counter wrapped");

    property p_rec_bound;
        @(posedge core_clk) disable iff (!rst_n)
        s_q.rec_cnt <= REC_FULL && s_q.wr_ptr <= REC_LAST;
    endproperty
    a_rec_bound: assert property (p_rec_bound)
        else $error("record store index out of range");

    property p_evt_stamp;
        @(posedge core_clk) disable iff (!rst_n)
        evt_out.valid |-> evt_out.stamp == $past(time_in);
    endproperty
    a_evt_stamp: assert property (p_evt_stamp)
        else $error("event time stamp wrong");

    c_start: cover property (@(posedge core_clk) $rose(start_out));
    c_block: cover property (@(posedge core_clk) $rose(blocked_out));
    c_wrap:  cover property (@(posedge core_clk)
        rec_we && s_q.wr_ptr == REC_LAST);

endmodule

// File: dv/pber_src_model.sv
`timescale 1ns/10ps

// ****************************************************************
// Blocking matrix and measurement source
// ****************************************************************
module pber_src_model #(
    parameter int CYC = 8
) (
    input  wire logic            core_clk,
    input  wire logic            rst_n,
    input  wire logic [2:0]      want,
    output logic                 cycle_en,
    output logic                 pickup_in,
    output logic                 block_in,
    output logic                 over_current_in,
    output logic [31:0]          time_in,
    output pber_pkg::pber_meas_t meas_in
);
    logic [7:0] div_q;

    // Program cycle strobe, free time base and input levels; pick-up, block
    // and over-current all copy want on the same clock, so their order is up to the test
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q           <= 8'h00;
            cycle_en        <= 1'b0;
            time_in         <= 32'h0000_1000;
            pickup_in       <= 1'b0;
            block_in        <= 1'b0;
            over_current_in <= 1'b0;
        end else begin
            div_q           <= (div_q == 8'(CYC - 1)) ? 8'h00 : div_q + 8'h01;
            cycle_en        <= (div_q == 8'h00);
            time_in         <= time_in + 32'h1;
            pickup_in       <= want[2];
            block_in        <= want[1];
            over_current_in <= want[0];
        end
    end

    // Fixed measurements, distinct per channel so swaps show up
    assign meas_in = {16'h0111, 16'h0222, 16'h0333, 16'h0aaa, 16'h0bbb,
                      16'h0ccc, 3'h5};
endmodule

// File: dv/tb_top.sv
`timescale 1ns/10ps

// ****************************************************************
// Bench top
// ****************************************************************
module tb_top;
    localparam int CYC = 8;
    // Narrow counters so that saturation is reached in a short run
    localparam int CNT_W = 3;
    localparam logic [31:0] CNT_MAX = 32'((1 << CNT_W) - 1);

    logic                    core_clk = 1'b0;
    logic                    rst_n;
    logic [2:0]              want;
    logic                    cycle_en;
    logic                    pickup_in;
    logic                    block_in;
    logic                    over_current_in;
    logic [31:0]             time_in;
    pber_pkg::pber_meas_t    meas_in;
    logic                    hsel;
    logic [7:0]              haddr;
    logic [1:0]              htrans;
    logic                    hwrite;
    logic [31:0]             hwdata;
    logic [2:0]              hsize;
    logic [31:0]             last_on;
    logic [31:0]             hrdata;
    logic                    hreadyout;
    logic                    hresp;
    logic                    start_out;
    logic                    trip_out;
    logic                    blocked_out;
    pber_pkg::pber_evt_msg_t evt_out;
    logic                    irq;
    logic [31:0]             s_rdata;
    logic                    s_rdy;
    logic [31:0]             prev_time;
    logic [5:0]              ev_seen;
    logic                    ev_clr;
    logic                    start_seen;
    int                      err_count;
    int                      samples_checked;

    // 125 MHz core clock
    always #4 core_clk = ~core_clk;

    pber_src_model #(.CYC(CYC)) src (.core_clk(core_clk), .rst_n(rst_n),
        .want(want), .cycle_en(cycle_en), .pickup_in(pickup_in),
        .block_in(block_in), .over_current_in(over_current_in),
        .time_in(time_in), .meas_in(meas_in));

    // Single slave: its hreadyout is the bus hready
    pber_core #(.CNT_W(CNT_W)) uut (.core_clk(core_clk), .rst_n(rst_n),
        .cycle_en(cycle_en), .block_in(block_in), .pickup_in(pickup_in),
        .over_current_in(over_current_in), .time_in(time_in),
        .meas_in(meas_in), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .start_out(start_out), .trip_out(trip_out),
        .blocked_out(blocked_out), .evt_out(evt_out), .irq(irq));

    // Edge samples taken before the design's updates land, so the
    // tasks never race the clock edge
    always @(posedge core_clk) begin
        s_rdata   <= hrdata;
        s_rdy     <= hreadyout;
        prev_time <= time_in;
        if (start_out === 1'b1)
            start_seen <= 1'b1;
        if (ev_clr) begin
            ev_seen    <= 6'h00;
            start_seen <= 1'b0;
        end else if (evt_out.valid === 1'b1) begin
            ev_seen[evt_out.code] <= 1'b1;
            if (evt_out.code == pber_pkg::PBER_EV_START_ON)
                last_on <= evt_out.stamp;
            chk("evt_stamp", evt_out.stamp, prev_time);
        end
    end

    task automatic chk(input string what, input logic [31:0] got,
                       input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // No wait count is assumed; ready ends the wait, or 64 cycles on a stuck bus
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (s_rdy !== 1'b1 && n < 64);
        if (s_rdy !== 1'b1) chk("bus_wait", 32'h0, 32'h1);
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= pber_pkg::HTRANS_NONSEQ;
        hsize  <= pber_pkg::HSIZE_WORD;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        q = s_rdata;
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdchk(input string w, input logic [7:0] a,
                         input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(w, q, exp);
    endtask

    // Pins need two syncs plus a program cycle before outputs move
    task automatic drive(input logic [2:0] v);
        want <= v;
        repeat (3 * CYC + 6) @(posedge core_clk);
        #1;
    endtask

    task automatic clr_ev;
        ev_clr <= 1'b1;
        @(posedge core_clk);
        #1;
        ev_clr <= 1'b0;
    endtask

    task automatic outs(input string w, input logic [2:0] e);
        chk(w, {29'h0, blocked_out, trip_out, start_out}, {29'h0, e});
        rdchk(w, pber_pkg::ADDR_STATUS, {29'h0, e});
    endtask

    task automatic t_start_irq;
        wr(pber_pkg::ADDR_IRQ_EN, 32'h0);
        clr_ev();
        drive(3'b100);
        outs("start", 3'b001);
        chk("ev_start", {26'h0, ev_seen}, 32'h1);
        rdchk("cnt_start", pber_pkg::ADDR_CNT_START, 32'h1);
        rdchk("irq_stat", pber_pkg::ADDR_IRQ_STAT, 32'h1);
        wr(pber_pkg::ADDR_IRQ_EN, 32'h2);
        drive(3'b100);
        chk("irq_masked", {31'h0, irq}, 32'h0);
        wr(pber_pkg::ADDR_IRQ_EN, 32'h1);
        drive(3'b100);
        chk("irq_on", {31'h0, irq}, 32'h1);
        wr(pber_pkg::ADDR_IRQ_CLR, 32'h3f);
        rdchk("irq_clr", pber_pkg::ADDR_IRQ_STAT, 32'h0);
        chk("irq_off", {31'h0, irq}, 32'h0);
        $display("test start_irq done");
    endtask

    task automatic t_trip_block;
        clr_ev();
        drive(3'b101);
        chk("trip", {31'h0, trip_out}, 32'h1);
        rdchk("cnt_trip", pber_pkg::ADDR_CNT_TRIP, 32'h1);
        drive(3'b000);
        chk("ev_trip", {26'h0, ev_seen}, 32'h0e);
        drive(3'b100);
        clr_ev();
        drive(3'b110);
        outs("blk_over_start", 3'b100);
        chk("ev_blk", {26'h0, ev_seen}, 32'h12);
        rdchk("cnt_blk", pber_pkg::ADDR_CNT_BLK, 32'h1);
        drive(3'b000);
        clr_ev();
        drive(3'b111);
        outs("blk_first", 3'b100);
        chk("no_start", {31'h0, start_seen}, 32'h0);
        drive(3'b000);
        $display("test trip_block done");
    endtask

    task automatic t_cfg_force;
        logic [2:0] st;
        for (int i = 1; i < 3; i++) begin
            wr(pber_pkg::ADDR_EVT_CFG, 32'(i));
            clr_ev();
            drive(3'b100);
            drive(3'b000);
            chk("ev_filter", {26'h0, ev_seen}, 32'(i));
        end
        wr(pber_pkg::ADDR_EVT_CFG, 32'h3f);
        drive(3'b100);
        for (int s = 0; s < 4; s++) begin
            wr(pber_pkg::ADDR_CTRL, 32'(s * 2 + 1));
            drive(3'b100);
            st = {blocked_out, trip_out, start_out};
            if (s == 0) chk("force_norm", {29'h0, st}, 32'h0);
            else chk("force_state", {31'h0, st[s-1]}, 32'h1);
        end
        wr(pber_pkg::ADDR_CTRL, 32'h0);
        drive(3'b000);
        wr(pber_pkg::ADDR_CTRL, 32'h70);
        for (int i = 0; i < 3; i++)
            rdchk("cnt_clr", 8'(12 + 4 * i), 32'h0);
        $display("test cfg_force done");
    endtask

    // Thirteen start ON records: the older trip and block ones must go
    task automatic t_records;
        logic [31:0] q;
        for (int i = 0; i < 13; i++) begin
            drive(3'b100);
            drive(3'b000);
        end
        bus(1'b0, pber_pkg::ADDR_REC_COUNT, 32'h0, q);
        chk("rec_cnt", {28'h0, q[3:0]}, 32'hc);
        rdchk("cnt_sat", pber_pkg::ADDR_CNT_START, CNT_MAX);
        // Newest record sits just behind the write pointer
        wr(pber_pkg::ADDR_REC_SEL, (q[7:4] == 4'h0)
           ? 32'(pber_pkg::REC_DEPTH - 1) : 32'(q[7:4] - 4'h1));
        rdchk("rec_time", pber_pkg::ADDR_REC_TIME, last_on);
        for (int i = 0; i < 12; i++) begin
            wr(pber_pkg::ADDR_REC_SEL, 32'(i));
            rdchk("rec_meta", pber_pkg::ADDR_REC_META, 32'h28);
            rdchk("rec_cur", pber_pkg::ADDR_REC_CUR, 32'h0222_0111);
            rdchk("rec_volt", pber_pkg::ADDR_REC_VOLT, 32'h0bbb_0aaa);
            rdchk("rec_ext", pber_pkg::ADDR_REC_EXT, 32'h0ccc_0333);
        end
        $display("test records done");
    endtask

    initial begin
        rst_n           = 1'b0;
        want            = 3'b000;
        {hsel, hwrite}  = 2'b00;
        haddr           = 8'h00;
        htrans          = 2'h0;
        hwdata          = 32'h0;
        hsize           = pber_pkg::HSIZE_WORD;
        ev_clr          = 1'b1;
        err_count       = 0;
        samples_checked = 0;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        clr_ev();
        chk("outs_rst", {29'h0, blocked_out, trip_out, start_out}, 32'h0);
        rdchk("evt_cfg", pber_pkg::ADDR_EVT_CFG, 32'h3f);
        rdchk("unmapped", 8'hfc, 32'h0);
        t_start_irq();
        t_trip_block();
        t_cfg_force();
        t_records();
        tally_and_finish();
    end

    // The run needs about 1600 cycles; this only cuts a hang short
    initial begin
        repeat (30000) @(posedge core_clk);
        err_count++;
        tally_and_finish();
    end
endmodule
